// File: bench/tb.sv
`timescale 1ns/1ps

module tb;
  logic clk, rst_n, uart_enable, fifo_enable, rx_flow_gate_enable;
  logic tx_flow_gate_enable, rts_sw_level, rx_dma_enable, tx_dma_enable;
  logic rx_dma_stop_on_error, rx_error_irq, clear_to_send_n;
  logic rx_req_clear, tx_req_clear, tx_data_valid, tx_shift_busy;
  logic [2:0] rx_level_sel, tx_level_sel;
  logic [5:0] rx_fill, tx_fill;
  logic [7:0] tx_data, tx_char;
  logic request_to_send_n, rx_single_req, rx_burst_req, tx_single_req;
  logic tx_burst_req, tx_data_ready, tx_start, cts_level_n, tx_halted;
  int error_cnt, cmp_count;
  logic [5:0] marks [5] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h1C};

  uart_flow_dma i_uart_flow_dma (.clk(clk), .rst_n(rst_n),
    .uart_enable(uart_enable), .fifo_enable(fifo_enable),
    .rx_flow_gate_enable(rx_flow_gate_enable),
    .tx_flow_gate_enable(tx_flow_gate_enable),
    .rts_sw_level(rts_sw_level), .rx_level_sel(rx_level_sel),
    .tx_level_sel(tx_level_sel), .rx_dma_enable(rx_dma_enable),
    .tx_dma_enable(tx_dma_enable),
    .rx_dma_stop_on_error(rx_dma_stop_on_error), .rx_fill(rx_fill),
    .tx_fill(tx_fill), .rx_error_irq(rx_error_irq),
    .clear_to_send_n(clear_to_send_n),
    .request_to_send_n(request_to_send_n), .rx_req_clear(rx_req_clear),
    .tx_req_clear(tx_req_clear), .rx_single_req(rx_single_req),
    .rx_burst_req(rx_burst_req), .tx_single_req(tx_single_req),
    .tx_burst_req(tx_burst_req), .tx_data_valid(tx_data_valid),
    .tx_data_ready(tx_data_ready), .tx_data(tx_data),
    .tx_shift_busy(tx_shift_busy), .tx_start(tx_start),
    .tx_char(tx_char), .cts_level_n(cts_level_n), .tx_halted(tx_halted));
  tx_shifter_model i_tx_shifter_model (.clk(clk), .rst_n(rst_n),
    .tx_start(tx_start), .tx_char(tx_char),
    .tx_shift_busy(tx_shift_busy));

  // Free-running block clock.
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // Waits, bounded, until the far side holds n characters.
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (i_tx_shifter_model.got_q.size() < n && k < 300)
    begin
      step(1);
      k++;
    end
    if (i_tx_shifter_model.got_q.size() < n)
    begin
      error_cnt++;
      results();
    end
  endtask : wait_got
  // Offers one character and holds it until it is taken.
  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    tx_data = d;
    tx_data_valid = 1'h1;
    while (!tx_data_ready && k < 300)
    begin
      step(1);
      k++;
    end
    if (!tx_data_ready)
    begin
      error_cnt++;
      results();
    end
    else
      step(1);
  endtask : push
  // one-cycle clear pulse from the DMA side.
  task automatic clr(input logic tx);
    if (tx)
      tx_req_clear = 1'h1;
    else
      rx_req_clear = 1'h1;
    step(1);
    {rx_req_clear, tx_req_clear} = 2'h0;
    step(1);
  endtask : clr

  task automatic t_rts;
    {uart_enable, rx_flow_gate_enable, rts_sw_level} = 3'h7;
    for (int i = 0; i < 5; i++)
    begin
      rx_level_sel = 3'(i);
      rx_fill = marks[i] - 6'h01;
      step(1);
      chk("rts below", request_to_send_n, 8'h00);
      rx_fill = marks[i];
      step(1);
      chk("rts at mark", request_to_send_n, 8'h01);
      rx_fill = marks[i] + 6'h01; // The character in flight still lands.
      step(1);
      chk("rts above mark", request_to_send_n, 8'h01);
    end
    rx_flow_gate_enable = 1'h0;
    step(1);
    chk("rts sw on", request_to_send_n, 8'h00);
  endtask : t_rts

  task automatic t_rx_dma;
    {rx_dma_enable, fifo_enable} = 2'h3;
    for (int i = 0; i < 5; i++)
    begin
      rx_level_sel = 3'(i);
      rx_fill = marks[i];
      clr(1'h0);
      chk("rx burst at mark", rx_burst_req, 8'h00);
      rx_fill = marks[i] + 6'h01;
      step(1);
      chk("rx burst", rx_burst_req, 8'h01);
      rx_fill = 6'h01;
      step(1);
      chk("rx burst held", rx_burst_req, 8'h01);
      rx_req_clear = 1'h1;
      step(1);
      chk("rx single cleared", rx_single_req, 8'h00);
      rx_req_clear = 1'h0;
      step(1);
      chk("rx single only", {rx_single_req, rx_burst_req}, 8'h02);
    end
  endtask : t_rx_dma

  task automatic t_rx_mask;
    rx_fill = 6'h05;
    rx_level_sel = 3'h0;
    {rx_dma_stop_on_error, rx_error_irq} = 2'h3;
    step(1);
    chk("rx masked", {rx_single_req, rx_burst_req}, 8'h00);
    rx_dma_stop_on_error = 1'h0;
    step(1);
    chk("rx unmasked", {rx_single_req, rx_burst_req}, 8'h03);
    {fifo_enable, rx_error_irq} = 2'h0;
    step(1);
    chk("char mode", {rx_single_req, rx_burst_req}, 8'h02);
    {fifo_enable, rx_dma_enable, tx_dma_enable} = 3'h5;
    step(1);
    chk("rx dir off", rx_single_req, 8'h00);
    {rx_dma_enable, uart_enable} = 2'h2;
    step(1);
    chk("all off", {rx_single_req, tx_single_req}, 8'h00);
    uart_enable = 1'h1;
  endtask : t_rx_mask

  task automatic t_tx_dma;
    tx_fill = 6'h20;
    clr(1'h1);
    chk("tx full", {tx_single_req, tx_burst_req}, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      tx_level_sel = 3'(i);
      tx_fill = marks[i];
      clr(1'h1);
      chk("tx at mark", {tx_single_req, tx_burst_req}, 8'h02);
      tx_fill = marks[i] - 6'h01;
      step(1);
      chk("tx burst", tx_burst_req, 8'h01);
    end
  endtask : t_tx_dma

  task automatic t_tx_path;
    {tx_flow_gate_enable, clear_to_send_n} = 2'h3;
    push(8'hA1);
    push(8'hB2);
    tx_data = 8'hC3;
    step(2);
    chk("buffer full", tx_data_ready, 8'h00);
    chk("halted", tx_halted, 8'h01);
    clear_to_send_n = 1'h0;
    step(2);
    chk("cts sync", cts_level_n, 8'h01);
    step(1);
    chk("cts low", cts_level_n, 8'h00);
    chk("halt released", tx_halted, 8'h00);
    push(8'hC3);
    tx_data_valid = 1'h0;
    wait_got(3);
    for (int i = 0; i < 3; i++)
      chk("order", i_tx_shifter_model.got_q[i], 8'hA1 + 8'(i * 8'h11));
    push(8'hD4);
    push(8'hE5);
    tx_data_valid = 1'h0;
    wait_got(4);
    clear_to_send_n = 1'h1;
    step(30);
    chk("stopped", 8'(i_tx_shifter_model.got_q.size()), 8'h04);
    chk("halted again", tx_halted, 8'h01);
    tx_flow_gate_enable = 1'h0;
    wait_got(5);
    chk("flow off", i_tx_shifter_model.got_q[4], 8'hE5);
    step(10);
    chk("drained", tx_data_ready, 8'h01);
  endtask : t_tx_path

  // Reset, then each scenario in turn.
  initial
  begin
    {rst_n, uart_enable, fifo_enable, rx_flow_gate_enable} = 4'h0;
    {tx_flow_gate_enable, rts_sw_level, rx_dma_enable} = 3'h0;
    {tx_dma_enable, rx_dma_stop_on_error, rx_error_irq} = 3'h0;
    {rx_req_clear, tx_req_clear, tx_data_valid} = 3'h0;
    {clear_to_send_n, rx_level_sel, tx_level_sel} = 7'h40;
    {rx_fill, tx_fill, tx_data} = 20'h00000;
    error_cnt = 0;
    cmp_count = 0;
    step(3);
    rst_n = 1'h1;
    chk("reset pins", {request_to_send_n, cts_level_n}, 8'h03);
    chk("reset reqs", {rx_single_req, tx_single_req, tx_halted}, 8'h00);
    // clears and requests all change on the one clock.
    t_rts();
    t_rx_dma();
    t_rx_mask();
    t_tx_dma();
    t_tx_path();
    results();
  end
endmodule : tb

// File: bench/tx_shifter_model.sv
`timescale 1ns/1ps

// Transmit shifter and the remote receiver behind it.
module tx_shifter_model #(
  parameter int BUSY_CYC = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Launch from the block.
  input wire logic tx_start,
  input wire logic [7:0] tx_char,
  output logic tx_shift_busy
);
  int cnt_q;
  logic [7:0] got_q [$];

  // Busy rises the cycle after a launch and lasts one frame.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= 0;
    else if (tx_start)
    begin
      cnt_q <= BUSY_CYC;
      got_q.push_back(tx_char);
    end
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
  end
  assign tx_shift_busy = (cnt_q != 0);
endmodule : tx_shifter_model

// File: bench/uart_flow_dma_properties.sv
`timescale 1ns/1ps

// ----
// Checker of the flow pin and the DMA request timing.
// ----
module uart_flow_dma_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Controls.
  input wire logic uart_enable,
  input wire logic fifo_enable,
  input wire logic rx_flow_gate_enable,
  input wire logic rts_sw_level,
  input wire logic [2:0] rx_level_sel,
  input wire logic rx_dma_enable,
  input wire logic rx_dma_stop_on_error,
  input wire logic [5:0] rx_fill,
  input wire logic rx_error_irq,
  input wire logic rx_req_clear,
  // Outputs.
  input wire logic request_to_send_n,
  input wire logic rx_single_req,
  input wire logic rx_burst_req,
  input wire logic tx_burst_req,
  input wire logic tx_start
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Receive requests are allowed only in this state.
  wire rx_ok = uart_enable && rx_dma_enable
    && !(rx_dma_stop_on_error && rx_error_irq);

  // Mark of a select code; spare codes fall to half.
  function automatic logic [5:0] mark(input logic [2:0] s);
    case (s)
      3'h0: mark = 6'h04;
      3'h1: mark = 6'h08;
      3'h3: mark = 6'h18;
      3'h4: mark = 6'h1C;
      default: mark = 6'h10;
    endcase
  endfunction : mark

  // A clear drops both receive requests next cycle.
  sequence s_clr;
    rx_req_clear ##1 (!rx_single_req && !rx_burst_req);
  endsequence
  // A launch lasts exactly one cycle.
  sequence s_pulse;
    tx_start ##1 !tx_start;
  endsequence

  property p_rts_full;
    rx_flow_gate_enable && rx_fill >= mark(rx_level_sel)
      |=> request_to_send_n;
  endproperty
  a_rts_full: assert property (p_rts_full)
    else $error("request pin low at mark");
  property p_rts_drain;
    rx_flow_gate_enable && rx_fill < mark(rx_level_sel)
      |=> !request_to_send_n;
  endproperty
  a_rts_drain: assert property (p_rts_drain)
    else $error("request pin high below mark");
  property p_rts_sw;
    !rx_flow_gate_enable |=> request_to_send_n == !$past(rts_sw_level);
  endproperty
  a_rts_sw: assert property (p_rts_sw)
    else $error("request pin polarity wrong");
  property p_rx_single;
    rx_ok && !rx_req_clear && rx_fill != 6'h00 |=> rx_single_req;
  endproperty
  a_rx_single: assert property (p_rx_single)
    else $error("receive single request missing");
  property p_rx_burst;
    $rose(rx_burst_req) |-> $past(rx_fill) > mark($past(rx_level_sel));
  endproperty
  a_rx_burst: assert property (p_rx_burst)
    else $error("receive burst rose at or below mark");
  property p_clear;
    rx_req_clear |-> s_clr;
  endproperty
  a_clear: assert property (p_clear)
    else $error("receive clear ignored");
  property p_hold;
    rx_single_req && rx_ok && !rx_req_clear |=> rx_single_req;
  endproperty
  a_hold: assert property (p_hold)
    else $error("receive single request dropped early");
  property p_stop;
    rx_dma_stop_on_error && rx_error_irq
      |=> !rx_single_req && !rx_burst_req;
  endproperty
  a_stop: assert property (p_stop)
    else $error("receive request during error");
  property p_char;
    !fifo_enable |=> !rx_burst_req && !tx_burst_req;
  endproperty
  a_char: assert property (p_char)
    else $error("burst request in character mode");
  property p_pulse;
    tx_start |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("launch pulse too long");
endmodule : uart_flow_dma_checker

bind uart_flow_dma uart_flow_dma_checker i_uart_flow_dma_checker (
  .clk(clk), .rst_n(rst_n), .uart_enable(uart_enable),
  .fifo_enable(fifo_enable), .rx_flow_gate_enable(rx_flow_gate_enable),
  .rts_sw_level(rts_sw_level), .rx_level_sel(rx_level_sel),
  .rx_dma_enable(rx_dma_enable),
  .rx_dma_stop_on_error(rx_dma_stop_on_error), .rx_fill(rx_fill),
  .rx_error_irq(rx_error_irq), .rx_req_clear(rx_req_clear),
  .request_to_send_n(request_to_send_n), .rx_single_req(rx_single_req),
  .rx_burst_req(rx_burst_req), .tx_burst_req(tx_burst_req),
  .tx_start(tx_start)
);

// File: design/cts_sync.sv
`timescale 1ns/1ps

module cts_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin level and its synchronised copy.
  input wire logic pin_n,
  output logic pin_sync_n
);

  logic meta_q;

  // Two flops in series; only the second stage leaves this module.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= uart_flow_pkg::PIN_IDLE_N;
      pin_sync_n <= uart_flow_pkg::PIN_IDLE_N;
    end
    else
    begin
      meta_q <= pin_n;
      pin_sync_n <= meta_q;
    end
  end

endmodule : cts_sync

// File: design/two_entry_buffer.sv
`timescale 1ns/1ps

module two_entry_buffer #(
  parameter int WIDTH = uart_flow_pkg::TX_CHAR_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [uart_flow_pkg::BUF_ENTRIES];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic push;
  logic pop;

  // Handshakes on both sides.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // Occupancy after this cycle's push and pop.
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 2'h1;
    else if (pop && !push)
      count_d = count_q - 2'h1;
  end

  // Storage write, indexed by the write pointer.
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // Pointers, count and the registered ready toward the source.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= 1'h0;
      rd_ptr_q <= 1'h0;
      count_q <= 2'h0;
      in_ready <= 1'h1;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_d;
      in_ready <= (count_d != 2'h2); // Full stalls the source.
    end
  end

endmodule : two_entry_buffer

// File: design/uart_flow_dma.sv
`timescale 1ns/1ps


module uart_flow_dma (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control bits.
  input wire logic uart_enable,
  input wire logic fifo_enable,
  input wire logic rx_flow_gate_enable,
  input wire logic tx_flow_gate_enable,
  input wire logic rts_sw_level,
  input wire logic [2:0] rx_level_sel,
  input wire logic [2:0] tx_level_sel,
  // DMA control bits.
  input wire logic rx_dma_enable,
  input wire logic tx_dma_enable,
  input wire logic rx_dma_stop_on_error,
  // FIFO fill levels and error state.
  input wire logic [uart_flow_pkg::LEVEL_W-1:0] rx_fill,
  input wire logic [uart_flow_pkg::LEVEL_W-1:0] tx_fill,
  input wire logic rx_error_irq,
  // Flow-control pins.
  input wire logic clear_to_send_n,
  output logic request_to_send_n,
  // DMA request and clear lines.
  input wire logic rx_req_clear,
  input wire logic tx_req_clear,
  output logic rx_single_req,
  output logic rx_burst_req,
  output logic tx_single_req,
  output logic tx_burst_req,
  // Characters from the transmit FIFO.
  input wire logic tx_data_valid,
  output logic tx_data_ready,
  input wire logic [uart_flow_pkg::TX_CHAR_W-1:0] tx_data,
  // Launch toward the transmit shifter.
  input wire logic tx_shift_busy,
  output logic tx_start,
  output logic [uart_flow_pkg::TX_CHAR_W-1:0] tx_char,
  // Status.
  output logic cts_level_n,
  output logic tx_halted
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Turns a watermark select code into a character count.
  function automatic logic [uart_flow_pkg::LEVEL_W-1:0] level_mark(
    input logic [2:0] sel
  );
    logic [uart_flow_pkg::LEVEL_W-1:0] mark;
    mark = uart_flow_pkg::MARK_HALF;
    case (sel)
      uart_flow_pkg::SEL_EIGHTH: mark = uart_flow_pkg::MARK_EIGHTH;
      uart_flow_pkg::SEL_QUARTER: mark = uart_flow_pkg::MARK_QUARTER;
      uart_flow_pkg::SEL_HALF: mark = uart_flow_pkg::MARK_HALF;
      uart_flow_pkg::SEL_THREE_QUARTER:
        mark = uart_flow_pkg::MARK_THREE_QUARTER;
      uart_flow_pkg::SEL_SEVEN_EIGHTH:
        mark = uart_flow_pkg::MARK_SEVEN_EIGHTH;
      default: mark = uart_flow_pkg::MARK_HALF;
    endcase
    return mark;
  endfunction : level_mark

  // Next value of one held DMA request.
  function automatic logic next_req(
    input logic held,
    input logic cond,
    input logic clr,
    input logic allow
  );
    logic result;
    result = 1'h0;
    if (!allow || clr)
      result = 1'h0;
    else
      result = held || cond;
    return result;
  endfunction : next_req

  // ----------------------------------------------------------------------
  // Watermarks and FIFO conditions
  // ----------------------------------------------------------------------

  logic [uart_flow_pkg::LEVEL_W-1:0] rx_mark;
  logic [uart_flow_pkg::LEVEL_W-1:0] tx_mark;
  logic rx_not_empty;
  logic rx_over_mark;
  logic rx_at_mark;
  logic tx_has_space;
  logic tx_under_mark;

  assign rx_mark = level_mark(rx_level_sel);
  assign tx_mark = level_mark(tx_level_sel);
  assign rx_not_empty = (rx_fill != 6'h00);
  assign rx_over_mark = (rx_fill > rx_mark);
  assign rx_at_mark = (rx_fill >= rx_mark);
  assign tx_has_space = (tx_fill < 6'(uart_flow_pkg::FIFO_DEPTH));
  assign tx_under_mark = (tx_fill < tx_mark);

  // ----------------------------------------------------------------------
  // Request-to-send output
  // ----------------------------------------------------------------------

  // The pin follows the watermark while receive flow control is on;
  // otherwise software's level reaches the pin inverted onto the low-true
  // line. With flow off nothing here throttles the receiver, so it keeps
  // taking characters until its FIFO refuses them.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      request_to_send_n <= uart_flow_pkg::PIN_IDLE_N;
    else if (rx_flow_gate_enable)
      request_to_send_n <= rx_at_mark;
    else
      request_to_send_n <= ~rts_sw_level;
  end

  // ----------------------------------------------------------------------
  // DMA request gating
  // ----------------------------------------------------------------------

  logic rx_allow;
  logic tx_allow;
  logic rx_masked;

  // A receive error with stop-on-error set holds the receive pair low
  // until the error interrupt or stop-on-error is cleared outside this block.
  // mask on error
  assign rx_masked = rx_dma_stop_on_error && rx_error_irq;
  assign rx_allow = uart_enable && rx_dma_enable && !rx_masked;
  assign tx_allow = uart_enable && tx_dma_enable;

  // ----------------------------------------------------------------------
  // DMA request registers
  // ----------------------------------------------------------------------

  // Each request is evaluated on its own, so single and burst can stand
  // together and the single one survives when the fill drops below the
  // mark. A clear in the same cycle as the condition wins: the clear is
  // the controller's acknowledgement of the request it already saw.
  // single clock domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_single_req <= uart_flow_pkg::REQ_IDLE;
      rx_burst_req <= uart_flow_pkg::REQ_IDLE;
      tx_single_req <= uart_flow_pkg::REQ_IDLE;
      tx_burst_req <= uart_flow_pkg::REQ_IDLE;
    end
    else
    begin
      rx_single_req <= next_req(rx_single_req, rx_not_empty,
                                rx_req_clear, rx_allow);
      rx_burst_req <= next_req(rx_burst_req, rx_over_mark,
                               rx_req_clear, rx_allow && fifo_enable);
      tx_single_req <= next_req(tx_single_req, tx_has_space,
                                tx_req_clear, tx_allow);
      tx_burst_req <= next_req(tx_burst_req, tx_under_mark,
                               tx_req_clear, tx_allow && fifo_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Clear-to-send synchroniser
  // ----------------------------------------------------------------------

  logic cts_sync_n;

  cts_sync u_cts_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_n(clear_to_send_n),
    .pin_sync_n(cts_sync_n)
  );

  // Reports the synchronised pin level.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cts_level_n <= uart_flow_pkg::PIN_IDLE_N;
    else
      cts_level_n <= cts_sync_n;
  end

  // ----------------------------------------------------------------------
  // Transmit character buffer
  // ----------------------------------------------------------------------

  logic buf_valid;
  logic buf_ready;
  logic [uart_flow_pkg::TX_CHAR_W-1:0] buf_data;

  // Holds characters while the launcher is stalled by the pin or the
  // shifter; a full buffer drops tx_data_ready so no word is lost.
  two_entry_buffer #(
    .WIDTH(uart_flow_pkg::TX_CHAR_W)
  ) u_tx_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tx_data_valid),
    .in_ready(tx_data_ready),
    .in_data(tx_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // ----------------------------------------------------------------------
  // Transmit launcher
  // ----------------------------------------------------------------------

  uart_flow_pkg::tx_state_t tx_state_q;
  uart_flow_pkg::tx_state_t tx_state_d;
  logic cts_ok;
  logic launch;

  // The pin is only looked at here, between characters; a character
  // already in the shifter runs to its stop bit whatever the pin does.
  // check before each character
  assign cts_ok = !tx_flow_gate_enable || !cts_sync_n;
  assign launch = (tx_state_q == uart_flow_pkg::TX_IDLE) && uart_enable &&
                  buf_valid && cts_ok && !tx_shift_busy;
  assign buf_ready = launch;

  // Idle, launch pulse, then wait for the shifter to take and finish.
  always_comb
  begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      uart_flow_pkg::TX_IDLE:
        if (launch)
          tx_state_d = uart_flow_pkg::TX_LAUNCH;
      uart_flow_pkg::TX_LAUNCH:
        tx_state_d = uart_flow_pkg::TX_WAIT_BUSY;
      uart_flow_pkg::TX_WAIT_BUSY:
        if (!tx_shift_busy)
          tx_state_d = uart_flow_pkg::TX_IDLE;
      default:
        tx_state_d = uart_flow_pkg::TX_IDLE;
    endcase
  end

  // State register of the launcher.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_state_q <= uart_flow_pkg::TX_IDLE;
    else
      tx_state_q <= tx_state_d;
  end

  // One-cycle start pulse with the character beside it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_start <= 1'h0;
      tx_char <= uart_flow_pkg::CHAR_RESET;
    end
    else
    begin
      tx_start <= launch;
      if (launch)
        tx_char <= buf_data;
    end
  end

  // Flags data waiting but held back by clear-to-send.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_halted <= 1'h0;
    else
      tx_halted <= uart_enable && buf_valid && !cts_ok;
  end

endmodule : uart_flow_dma

// File: design/uart_flow_pkg.sv
package uart_flow_pkg;

  // ----------------------------------------------------------------------
  // FIFO geometry and character widths
  // ----------------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int LEVEL_W = 6;
  localparam int RX_CHAR_W = 12;
  localparam int TX_CHAR_W = 8;
  localparam int BUF_ENTRIES = 2;

  // ----------------------------------------------------------------------
  // Watermark select codes and their character marks
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_EIGHTH = 3'h0;
  localparam logic [2:0] SEL_QUARTER = 3'h1;
  localparam logic [2:0] SEL_HALF = 3'h2;
  localparam logic [2:0] SEL_THREE_QUARTER = 3'h3;
  localparam logic [2:0] SEL_SEVEN_EIGHTH = 3'h4;
  localparam logic [LEVEL_W-1:0] MARK_EIGHTH = 6'h04;
  localparam logic [LEVEL_W-1:0] MARK_QUARTER = 6'h08;
  localparam logic [LEVEL_W-1:0] MARK_HALF = 6'h10;
  localparam logic [LEVEL_W-1:0] MARK_THREE_QUARTER = 6'h18;
  localparam logic [LEVEL_W-1:0] MARK_SEVEN_EIGHTH = 6'h1C;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic PIN_IDLE_N = 1'h1;
  localparam logic REQ_IDLE = 1'h0;
  localparam logic [TX_CHAR_W-1:0] CHAR_RESET = 8'h00;

  // Transmit launcher states.
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LAUNCH,
    TX_WAIT_BUSY
  } tx_state_t;

endpackage : uart_flow_pkg
